// *** core/acwd_map.svh ***
`ifndef ACWD_MAP_SVH
`define ACWD_MAP_SVH
// ==========================================================
// register addresses in the special-function space
`define ACWD_CTL_ADDR      8'he8
`define ACWD_CFG_ADDR      8'hbc
`define ACWD_RES_HI_ADDR   8'hbd
`define ACWD_RES_LO_ADDR   8'hbe
`define ACWD_GT_HI_ADDR    8'hc3
`define ACWD_GT_LO_ADDR    8'hc4
`define ACWD_LT_HI_ADDR    8'hc5
`define ACWD_LT_LO_ADDR    8'hc6
// ==========================================================
// reset values
`define ACWD_CTL_RESET     8'h00
`define ACWD_CFG_RESET     8'hf8
`define ACWD_GT_RESET      16'hffff
`define ACWD_LT_RESET      16'h0000
// ==========================================================
// field positions
`define ACWD_CTL_BUSY_BIT  4
`define ACWD_CFG_LJST_BIT  2
`define ACWD_CFG_SC_MSB    7
`define ACWD_CFG_SC_LSB    3
// ==========================================================
// start source codes
`define ACWD_CM_SOFT       3'h0
`define ACWD_CM_TMR0       3'h1
`define ACWD_CM_TMR2       3'h2
`define ACWD_CM_TMR1       3'h3
`define ACWD_CM_PIN        3'h4
`define ACWD_CM_TMR3       3'h5
// ==========================================================
// timing: low-power tracking length in sar clocks
`define ACWD_LP_TRACK_CLKS 2'h3
`endif

// *** core/acwd_pkg.sv ***
package acwd_pkg;
   // ==========================================================
   // control register layout, msb first as the register reads
   typedef struct packed {
      logic       enable;
      logic       track_mode;
      logic       done;
      logic       busy;
      logic       wint;
      logic [2:0] start_sel;
   } acwd_ctl_t;

   typedef struct packed {
      logic [15:0] gt;
      logic [15:0] lt;
   } acwd_limits_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK,
      ST_CONV
   } acwd_state_t;
endpackage : acwd_pkg

// *** core/acwd_window_cmp.sv ***
`timescale 1ns/10ps
module acwd_window_cmp (
   // formatted result and limits
   input  wire logic                  [15:0] value_i,
   input  wire acwd_pkg::acwd_limits_t       limits_i,
   input  wire logic                         signed_i,
   // verdict
   output logic                              match_o
);
   logic signed [16:0] val_s;
   logic signed [16:0] gt_s;
   logic signed [16:0] lt_s;

   // one extra msb makes a single signed compare serve both modes
   assign val_s = {signed_i & value_i[15], value_i};
   assign gt_s  = {signed_i & limits_i.gt[15], limits_i.gt};
   assign lt_s  = {signed_i & limits_i.lt[15], limits_i.lt};

   always_comb begin
      if (lt_s > gt_s) begin
         match_o = (val_s > gt_s) && (val_s < lt_s);
      end else begin
         match_o = (val_s < lt_s) || (val_s > gt_s);
      end
   end
endmodule : acwd_window_cmp

// *** core/acwd_top.sv ***
`timescale 1ns/10ps
`include "acwd_map.svh"
// Behaviour
// - enable bit clear keeps converter powered down; set makes it ready
// - normal track mode: track continuously while enabled, except during conversion
// - every finished result is compared against limits; match raises window flag
// - window flag sits in control register and can be polled
// - greater and less limits, each built from high and low byte registers
// - inside or outside detection chosen only by relative limit values
// - less above greater: flag when result strictly between the two
// - otherwise flag when result strictly below lower or above upper bound
// - differential results compare signed, single-ended compare unsigned
module acwd_top (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // special-function register bus
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   // start sources and mux mode
   input  wire logic [3:0] tmr_ovf_i,
   input  wire logic       cnvstr_i,
   input  wire logic       diff_mode_i,
   // sar core
   input  wire logic       sar_done_i,
   input  wire logic [9:0] sar_result_i,
   output logic            sar_power_o,
   output logic            sar_track_o,
   output logic            sar_start_o,
   output logic            sar_clk_en_o,
   // status levels
   output logic            conv_done_o,
   output logic            window_match_o
);
   // ==========================================================
   // state
   acwd_pkg::acwd_ctl_t    ctl_reg,    ctl_next;
   acwd_pkg::acwd_limits_t lim_reg,    lim_next;
   acwd_pkg::acwd_state_t  state_reg,  state_next;
   logic [7:0]             cfg_reg,    cfg_next;
   logic [15:0]            result_reg, result_next;
   logic [4:0]             div_reg,    div_next;
   logic [1:0]             trk_reg,    trk_next;
   logic                   pin_reg;
   logic [7:0]             rdata_next;
   logic                   track_next;
   logic                   start_next;
   logic                   sar_en;
   logic                   wr_ctl;
   logic                   sw_go;
   logic                   hw_go;
   logic [15:0]            fmt_value;
   logic                   match;

   // ==========================================================
   // result formatting and window compare
   always_comb begin
      if (cfg_reg[`ACWD_CFG_LJST_BIT]) begin
         fmt_value = {sar_result_i, 6'h00};
      end else begin
         fmt_value = {{6{diff_mode_i & sar_result_i[9]}}, sar_result_i};
      end
   end

   // the limits fix inside or outside; no mode bit exists
   acwd_window_cmp u_cmp (
      .value_i  (fmt_value),
      .limits_i (lim_reg),
      .signed_i (diff_mode_i),
      .match_o  (match)
   );

   // ==========================================================
   // next-state logic
   always_comb begin
      ctl_next    = ctl_reg;
      lim_next    = lim_reg;
      cfg_next    = cfg_reg;
      result_next = result_reg;
      state_next  = state_reg;
      trk_next    = trk_reg;
      start_next  = 1'b0;
      sar_en      = (div_reg == 5'h00);
      div_next    = sar_en ? cfg_reg[`ACWD_CFG_SC_MSB:`ACWD_CFG_SC_LSB] : div_reg - 5'h01;
      wr_ctl      = sfr_wr_i && (sfr_addr_i == `ACWD_CTL_ADDR);
      // busy write of zero does nothing; one only counts for software source
      sw_go = wr_ctl && sfr_wdata_i[`ACWD_CTL_BUSY_BIT]
              && (sfr_wdata_i[2:0] == `ACWD_CM_SOFT);
      case (ctl_reg.start_sel)
         `ACWD_CM_TMR0: hw_go = tmr_ovf_i[0];
         `ACWD_CM_TMR2: hw_go = tmr_ovf_i[2];
         `ACWD_CM_TMR1: hw_go = tmr_ovf_i[1];
         `ACWD_CM_PIN:  hw_go = cnvstr_i && !pin_reg;
         `ACWD_CM_TMR3: hw_go = tmr_ovf_i[3];
         default:       hw_go = 1'b0;
      endcase

      if (wr_ctl) begin
         ctl_next      = acwd_pkg::acwd_ctl_t'(sfr_wdata_i);
         ctl_next.busy = ctl_reg.busy;
      end
      if (sfr_wr_i) begin
         unique case (sfr_addr_i)
            `ACWD_CFG_ADDR:   cfg_next          = sfr_wdata_i;
            `ACWD_GT_HI_ADDR: lim_next.gt[15:8] = sfr_wdata_i;
            `ACWD_GT_LO_ADDR: lim_next.gt[7:0]  = sfr_wdata_i;
            `ACWD_LT_HI_ADDR: lim_next.lt[15:8] = sfr_wdata_i;
            `ACWD_LT_LO_ADDR: lim_next.lt[7:0]  = sfr_wdata_i;
            default: ;
         endcase
      end

      unique case (state_reg)
         acwd_pkg::ST_IDLE: begin
            if (ctl_reg.enable && (sw_go || hw_go)) begin
               if (ctl_reg.track_mode && (ctl_reg.start_sel != `ACWD_CM_PIN)) begin
                  state_next = acwd_pkg::ST_TRACK;
                  trk_next   = `ACWD_LP_TRACK_CLKS;
               end else begin
                  state_next = acwd_pkg::ST_CONV;
                  start_next = 1'b1;
               end
            end
         end
         acwd_pkg::ST_TRACK: begin
            if (sar_en) begin
               trk_next = trk_reg - 2'h1;
               if (trk_reg == 2'h1) begin
                  state_next = acwd_pkg::ST_CONV;
                  start_next = 1'b1;
               end
            end
         end
         acwd_pkg::ST_CONV: begin
            if (sar_done_i) begin
               state_next    = acwd_pkg::ST_IDLE;
               result_next   = fmt_value;
               // set wins over a same-cycle software clear
               ctl_next.done = 1'b1;
               if (match) begin
                  ctl_next.wint = 1'b1;
               end
            end
         end
      endcase

      // clearing enable aborts any conversion and powers down in the same edge,
      // so a start pulse never leaves while the converter is unpowered
      if (!ctl_next.enable) begin
         state_next = acwd_pkg::ST_IDLE;
         start_next = 1'b0;
      end
      ctl_next.busy = (state_next != acwd_pkg::ST_IDLE);

      if (!ctl_next.enable) begin
         track_next = 1'b0;
      end else if (!ctl_next.track_mode) begin
         track_next = (state_next != acwd_pkg::ST_CONV);
      end else begin
         track_next = (state_next == acwd_pkg::ST_TRACK)
                      || ((ctl_next.start_sel == `ACWD_CM_PIN) && !cnvstr_i
                          && (state_next == acwd_pkg::ST_IDLE));
      end

      rdata_next = 8'h00;
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            `ACWD_CTL_ADDR:    rdata_next = ctl_reg;
            `ACWD_CFG_ADDR:    rdata_next = {cfg_reg[7:3], cfg_reg[2], 2'b00};
            `ACWD_RES_HI_ADDR: rdata_next = result_reg[15:8];
            `ACWD_RES_LO_ADDR: rdata_next = result_reg[7:0];
            `ACWD_GT_HI_ADDR:  rdata_next = lim_reg.gt[15:8];
            `ACWD_GT_LO_ADDR:  rdata_next = lim_reg.gt[7:0];
            `ACWD_LT_HI_ADDR:  rdata_next = lim_reg.lt[15:8];
            `ACWD_LT_LO_ADDR:  rdata_next = lim_reg.lt[7:0];
            default:           rdata_next = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg        <= acwd_pkg::acwd_ctl_t'(`ACWD_CTL_RESET);
         cfg_reg        <= `ACWD_CFG_RESET;
         lim_reg        <= {`ACWD_GT_RESET, `ACWD_LT_RESET};
         result_reg     <= 16'h0000;
         state_reg      <= acwd_pkg::ST_IDLE;
         div_reg        <= 5'h00;
         trk_reg        <= 2'h0;
         pin_reg        <= 1'b0;
         sfr_rdata_o    <= 8'h00;
         sar_power_o    <= 1'b0;
         sar_track_o    <= 1'b0;
         sar_start_o    <= 1'b0;
         sar_clk_en_o   <= 1'b0;
         conv_done_o    <= 1'b0;
         window_match_o <= 1'b0;
      end else begin
         ctl_reg        <= ctl_next;
         cfg_reg        <= cfg_next;
         lim_reg        <= lim_next;
         result_reg     <= result_next;
         state_reg      <= state_next;
         div_reg        <= div_next;
         trk_reg        <= trk_next;
         pin_reg        <= cnvstr_i;
         sfr_rdata_o    <= rdata_next;
         sar_power_o    <= ctl_next.enable;
         sar_track_o    <= track_next;
         sar_start_o    <= start_next;
         sar_clk_en_o   <= sar_en;
         conv_done_o    <= ctl_next.done;
         window_match_o <= ctl_next.wint;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic signed [16:0] chk_val, chk_gt, chk_lt;
   assign chk_val = {diff_mode_i & fmt_value[15], fmt_value};
   assign chk_gt  = {diff_mode_i & lim_reg.gt[15], lim_reg.gt};
   assign chk_lt  = {diff_mode_i & lim_reg.lt[15], lim_reg.lt};

   power_down_a: assert property (!sar_power_o |-> !sar_start_o && !sar_track_o)
      else $error("converter active while disabled");
   track_cont_a: assert property (ctl_reg.enable && !ctl_reg.track_mode
      && state_reg == acwd_pkg::ST_IDLE && !wr_ctl |-> sar_track_o)
      else $error("not tracking while idle in normal mode");
   done_flag_a: assert property (state_reg == acwd_pkg::ST_CONV && sar_done_i && ctl_reg.enable
      |=> ctl_reg.done && !ctl_reg.busy ##1 conv_done_o)
      else $error("done flag or busy wrong at completion");
   window_set_a: assert property (state_reg == acwd_pkg::ST_CONV && sar_done_i && ctl_reg.enable
      && match |=> ctl_reg.wint)
      else $error("window flag missed");
   poll_read_a: assert property (sfr_rd_i && sfr_addr_i == `ACWD_CTL_ADDR
      |=> sfr_rdata_o[3] == $past(ctl_reg.wint))
      else $error("window flag not readable");
   sw_start_a: assert property (sw_go && ctl_reg.enable && !ctl_reg.track_mode && ctl_next.enable
      && state_reg == acwd_pkg::ST_IDLE |=> sar_start_o && ctl_reg.busy ##1 !sar_start_o)
      else $error("software start not honoured");
   inside_win_a: assert property (match && chk_lt > chk_gt |-> chk_val > chk_gt && chk_val < chk_lt)
      else $error("inside match outside window");
   outside_win_a: assert property (chk_lt <= chk_gt |-> match == (chk_val < chk_lt || chk_val > chk_gt))
      else $error("outside match wrong");
   lp_track_a: assert property ($rose(state_reg == acwd_pkg::ST_TRACK) |-> sar_track_o && !sar_start_o)
      else $error("low-power tracking phase not tracking");
endmodule : acwd_top

// *** bench/acwd_sar_model.sv ***
`timescale 1ns/10ps
// ====
// sar core stand-in: converts for a fixed count of sar clocks
module acwd_sar_model #(
   parameter int CONV_CLKS = 10
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // from the control block
   input  wire logic       start_i,
   input  wire logic       clk_en_i,
   input  wire logic       power_i,
   input  wire logic [9:0] value_i,
   // back to the control block
   output logic            done_o,
   output logic      [9:0] result_o
);
   int         cnt = 0;
   logic [9:0] held = 10'h000;
   always @(posedge clk_i) begin
      // one-cycle pulse as the last sar clock of the count is used up
      done_o <= !rst_i && power_i && !start_i && clk_en_i && (cnt == 1);
      if (rst_i || !power_i) begin
         cnt <= 0;
      end else if (start_i) begin
         cnt  <= CONV_CLKS;
         held <= value_i;
      end else if (cnt > 0 && clk_en_i) begin
         cnt <= cnt - 1;
      end
   end
   // outside the done pulse the result lines carry a stale, inverted pattern
   assign result_o = done_o ? held : ~held;
endmodule : acwd_sar_model

// *** bench/tb.sv ***
`timescale 1ns/10ps
`include "acwd_map.svh"
module tb;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] addr  = 8'h00;
   logic       wr    = 1'b0;
   logic       rd    = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [3:0] tmr   = 4'h0;
   logic       pin   = 1'b0;
   logic       diff  = 1'b0;
   logic [9:0] value = 10'h000;
   logic [7:0] rdata;
   logic       done, start, clk_en, power, track, conv_done, wmatch;
   logic [9:0] result;
   int         fail_count = 0;
   int         n_checks   = 0;
   always #50 clk_i = ~clk_i;
   acwd_top i_acwd_top (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .tmr_ovf_i(tmr), .cnvstr_i(pin), .diff_mode_i(diff),
      .sar_done_i(done), .sar_result_i(result), .sar_power_o(power), .sar_track_o(track),
      .sar_start_o(start), .sar_clk_en_o(clk_en), .conv_done_o(conv_done), .window_match_o(wmatch));
   acwd_sar_model i_acwd_sar_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .clk_en_i(clk_en),
      .power_i(power), .value_i(value), .done_o(done), .result_o(result));
   // ====
   // shared tasks
   task automatic close_out;
      if (fail_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk
   task automatic wait_done;
      for (int i = 0; i < 1000 && conv_done !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (conv_done !== 1'b1) begin
         fail_count++;
         close_out();
      end
   endtask : wait_done
   task automatic set_lim(input logic [15:0] gt, input logic [15:0] lt);
      wr_reg(`ACWD_GT_HI_ADDR, gt[15:8]);
      wr_reg(`ACWD_GT_LO_ADDR, gt[7:0]);
      wr_reg(`ACWD_LT_HI_ADDR, lt[15:8]);
      wr_reg(`ACWD_LT_LO_ADDR, lt[7:0]);
   endtask : set_lim
   task automatic fire(input logic [4:0] t);
      @(posedge clk_i);
      tmr <= t[3:0];
      pin <= t[4];
      @(posedge clk_i);
      tmr <= 4'h0;
      pin <= 1'b0;
   endtask : fire
   // ====
   // scenarios
   task automatic t_reset;
      int n = 0;
      // reset divider value gives one sar clock enable every 32 system clocks
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_i);
         #1;
         n += clk_en;
      end
      chk(n[15:0], 16'h0002);
      rd_chk(`ACWD_CTL_ADDR, `ACWD_CTL_RESET);
      rd_chk(`ACWD_CFG_ADDR, `ACWD_CFG_RESET);
      rd_chk(`ACWD_GT_HI_ADDR, 8'hff);
      rd_chk(`ACWD_LT_LO_ADDR, 8'h00);
      rd_chk(8'h00, 8'h00);
      chk(power, 1'b0);
   endtask : t_reset
   task automatic t_disabled;
      wr_reg(`ACWD_CTL_ADDR, 8'h10);
      repeat (3) @(posedge clk_i);
      #1;
      chk({start, track, power}, 16'h0000);
      rd_chk(`ACWD_CTL_ADDR, 8'h00);
      wr_reg(`ACWD_CTL_ADDR, 8'h80);
      repeat (2) @(posedge clk_i);
      #1;
      chk({power, track}, 16'h0003);
   endtask : t_disabled
   task automatic conv(input logic [9:0] v, input logic exp_w);
      value <= v;
      wr_reg(`ACWD_CTL_ADDR, 8'h80);
      wr_reg(`ACWD_CTL_ADDR, 8'h90);
      #1;
      chk(start, 1'b1);
      @(posedge clk_i);
      #1;
      chk({track, start}, 16'h0000);
      rd_chk(`ACWD_CTL_ADDR, 8'h90);
      wait_done;
      rd_chk(`ACWD_CTL_ADDR, {4'ha, exp_w, 3'h0});
      chk(wmatch, exp_w);
      chk(track, 1'b1);
   endtask : conv
   task automatic t_sources;
      // bit n is timer n, bit 4 the start pin, indexed by source code
      logic [4:0] trig [1:5] = '{5'h01, 5'h04, 5'h02, 5'h10, 5'h08};
      for (int c = 1; c <= 5; c++) begin
         wr_reg(`ACWD_CTL_ADDR, 8'h80);
         wr_reg(`ACWD_CTL_ADDR, 8'h90 | 8'(c));
         fire(~trig[c]);
         repeat (20) @(posedge clk_i);
         #1;
         chk(conv_done, 1'b0);
         fire(trig[c]);
         wait_done;
         rd_chk(`ACWD_CTL_ADDR, 8'ha0 | 8'(c));
      end
   endtask : t_sources
   task automatic t_low_power;
      // software start: three sar clocks of tracking, busy already set
      wr_reg(`ACWD_CTL_ADDR, 8'hc0);
      wr_reg(`ACWD_CTL_ADDR, 8'hd0);
      #1;
      chk({track, start}, 16'h0002);
      rd_chk(`ACWD_CTL_ADDR, 8'hd0);
      wait_done;
      rd_chk(`ACWD_CTL_ADDR, 8'he0);
      chk(track, 1'b0);
      // pin source: track while the pin is low, convert on its rising edge
      wr_reg(`ACWD_CTL_ADDR, 8'hc4);
      #1;
      chk(track, 1'b1);
      fire(5'h10);
      wait_done;
      rd_chk(`ACWD_CTL_ADDR, 8'he4);
      chk(track, 1'b1);
   endtask : t_low_power
   // ====
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_disabled();
      conv(10'h155, 1'b0);
      rd_chk(`ACWD_RES_HI_ADDR, 8'h01);
      rd_chk(`ACWD_RES_LO_ADDR, 8'h55);
      // fastest sar clock keeps the remaining conversions short
      wr_reg(`ACWD_CFG_ADDR, 8'h00);
      set_lim(16'h0040, 16'h0080);
      conv(10'h041, 1'b1);
      conv(10'h040, 1'b0);
      conv(10'h080, 1'b0);
      conv(10'h07f, 1'b1);
      set_lim(16'h0080, 16'h0040);
      conv(10'h03f, 1'b1);
      conv(10'h040, 1'b0);
      conv(10'h080, 1'b0);
      conv(10'h081, 1'b1);
      diff <= 1'b1;
      set_lim(16'hffff, 16'h0040);
      conv(10'h000, 1'b1);
      conv(10'h3ff, 1'b0);
      set_lim(16'h0040, 16'hffff);
      conv(10'h020, 1'b0);
      conv(10'h3fe, 1'b1);
      diff <= 1'b0;
      wr_reg(`ACWD_CFG_ADDR, 8'h04);
      set_lim(16'h1000, 16'h2000);
      conv(10'h041, 1'b1);
      rd_chk(`ACWD_RES_HI_ADDR, 8'h10);
      rd_chk(`ACWD_RES_LO_ADDR, 8'h40);
      wr_reg(`ACWD_CFG_ADDR, 8'h00);
      set_lim(16'hffff, 16'h0000);
      t_sources();
      t_low_power();
      close_out();
   end
endmodule : tb
